// file: icss_pkg.sv
// Constants and types for the inductive channel scan sequencer
package icss_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int ADDR_W = 8;       // Register address width
    localparam int DATA_W = 32;      // Register data width
    localparam int NCH    = 4;       // Sensor channels
    localparam int RC_W   = 16;      // Reference count width
    localparam int RES_W  = 28;      // Result width
    localparam int CNT_W  = 21;      // Reference edge counter width
    localparam int IRQ_W  = 2;       // Status and mask width
    localparam int DEAD_W = 8;       // Dead time counter width

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] OFS_RES   = 8'h00; // Ch n high 8n, low 8n+4
    localparam logic [7:0] OFS_RCNT  = 8'h20; // Ch n ref count at 20+4n
    localparam logic [7:0] OFS_CFG   = 8'h30; // Configuration
    localparam logic [7:0] OFS_STAT  = 8'h34; // Sticky events, W1C
    localparam logic [7:0] OFS_MASK  = 8'h38; // Interrupt mask
    localparam logic [7:0] OFS_STATE = 8'h3C; // Live sequencer state

    // ==========================================================
    // Fields and reset values
    // ==========================================================
    localparam int CFG_DIS_BIT = 0;  // irq_output_disable
    localparam int CFG_SEQ_BIT = 1;  // Channel sequence mode
    localparam int CFG_RUN_BIT = 2;  // Conversions enabled
    localparam int ST_DONE_BIT = 0;  // Scan finished
    localparam int ST_OVR_BIT  = 1;  // Scan overwrote unread data
    localparam int RES_SPLIT   = 16; // Low result half width
    localparam logic [2:0]       CFG_RST  = 3'h2;
    localparam logic [RC_W-1:0]  RCNT_RST = 16'h0080;
    localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

    // ==========================================================
    // Bus addresses and timing
    // ==========================================================
    localparam logic [6:0] I2C_ADDR_LOW  = 7'h2A; // Select pin low
    localparam logic [6:0] I2C_ADDR_HIGH = 7'h2B; // Select pin high
    localparam int CONV_MUL = 16;    // Ref periods per count
    localparam int CONV_ADD = 4;     // Extra ref periods
    localparam int CLK_NS   = 4;     // System clock period
    localparam int DEAD_NS  = 500;   // Channel switch dead time
    localparam int DEAD_CYC = DEAD_NS / CLK_NS;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } icss_bus_req_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b001,
        S_CONV   = 3'b010,
        S_SWITCH = 3'b100
    } icss_state_t;

endpackage

// file: icss_scan_seq.sv
// Four channel inductive scan sequencer with register port
`timescale 1ns/10ps
// Contract
// (R1) One channel converts at a time, in order
// (R2) Conversion lasts count times 16 plus 4
// (R3) Scan ends after all four channels convert
// (R4) Scan end loads results, asserts data ready
// (R5) Host reads results; data ready then clears
// (R6) Next conversion starts without waiting for read
// (R7) Data ready pin driven only when enabled
// (R8) Channel switch dead time below one microsecond
// (R9) Bus address 0x2A or 0x2B from pin
// (R10) Sequence mode cycles channels autonomously
// (R11) All results update together at scan end
module icss_scan_seq (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rstn_i,
    input  wire icss_pkg::icss_bus_req_t bus_i,
    output logic [icss_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                  ref_clk_i,
    input  wire logic [icss_pkg::NCH-1:0] sensor_i,
    input  wire logic                  addr_sel_i,
    output logic                       data_ready_irq_n_o,
    output logic                       data_ready_irq_oe_o,
    output logic                       irq_o,
    output logic [6:0]                 i2c_dev_addr_o
);
    import icss_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic           ref_s1, ref_s2, ref_s3;  // Reference clock stages
    logic [NCH-1:0] sen_s1, sen_s2, sen_s3;  // Sensor stages
    logic           sel_s1, sel_s2;          // Address pin stages

    // Two flops per pin, third flop only for edge finding
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
            sen_s1 <= '0;
            sen_s2 <= '0;
            sen_s3 <= '0;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else begin
            ref_s1 <= ref_clk_i;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
            sen_s1 <= sensor_i;
            sen_s2 <= sen_s1;
            sen_s3 <= sen_s2;
            sel_s1 <= addr_sel_i;
            sel_s2 <= sel_s1;
        end
    end

    // ==========================================================
    // Registers and state
    // ==========================================================
    logic [RC_W-1:0]  rcount [NCH];   // channel_ref_count per channel
    logic [2:0]       cfg;            // Configuration bits
    logic [IRQ_W-1:0] stat;           // Sticky events
    logic [IRQ_W-1:0] mask;           // Interrupt mask
    logic [RES_W-1:0] res    [NCH];   // Published results
    logic [RES_W-1:0] shadow [NCH];   // Results of the scan in flight
    icss_state_t      st;             // Sequencer state
    logic [1:0]       chan;           // Active channel
    logic [CNT_W-1:0] ref_cnt;        // Reference edges this channel
    logic [RES_W-1:0] sens_cnt;       // Sensor edges this channel
    logic [DEAD_W-1:0] dead_cnt;      // Switch dead time cycles
    logic             unread;         // Fresh data not yet read

    // ==========================================================
    // Derived terms
    // ==========================================================
    logic             ref_rise;       // Reference clock rising edge
    logic [NCH-1:0]   sens_rise;      // Sensor rising edges
    logic [CNT_W-1:0] conv_len;       // channel_conversion_time
    logic             conv_end;       // Channel conversion finishes
    logic             scan_done;      // Full scan finishes
    logic [RES_W-1:0] sens_next;      // Sensor count incl. this edge
    logic             res_rd;         // Host reads a result register
    logic             dis;            // irq_output_disable
    logic             seq;            // Channel sequence mode
    logic             run;            // Conversions enabled

    assign ref_rise  = ref_s2 & ~ref_s3;
    assign sens_rise = sen_s2 & ~sen_s3;
    assign dis       = cfg[CFG_DIS_BIT];
    assign seq       = cfg[CFG_SEQ_BIT];
    assign run       = cfg[CFG_RUN_BIT];
    // Length in reference periods of the active channel [R2]
    assign conv_len  = CNT_W'(rcount[chan]) * CNT_W'(CONV_MUL)
                     + CNT_W'(CONV_ADD);
    assign conv_end  = (st == S_CONV) && ref_rise
                     && (ref_cnt == conv_len - CNT_W'(1)); // [R2]
    assign scan_done = conv_end && (chan == 2'(NCH - 1)); // [R3]
    assign sens_next = sens_cnt + RES_W'(sens_rise[chan]);
    assign res_rd    = bus_i.rd && (bus_i.addr < OFS_RCNT);

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Steps channels one at a time with a dead time between them
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st       <= S_IDLE;
            chan     <= 2'h0;
            ref_cnt  <= '0;
            sens_cnt <= '0;
            dead_cnt <= '0;
        end else begin
            case (st)
                S_IDLE: begin
                    // Start a scan at channel zero
                    if (run) begin
                        st       <= S_CONV;
                        chan     <= 2'h0;
                        ref_cnt  <= '0;
                        sens_cnt <= '0;
                    end
                end
                S_CONV: begin
                    // Only the active channel is counted [R1]
                    sens_cnt <= sens_next;
                    if (ref_rise) begin
                        ref_cnt <= ref_cnt + CNT_W'(1);
                    end
                    if (conv_end) begin
                        st       <= S_SWITCH;
                        chan     <= chan + 2'h1; // [R1]
                        dead_cnt <= '0;
                    end
                end
                S_SWITCH: begin
                    // Short dead time, then next channel [R8]
                    dead_cnt <= dead_cnt + DEAD_W'(1);
                    if (dead_cnt == DEAD_W'(DEAD_CYC - 1)) begin
                        ref_cnt  <= '0;
                        sens_cnt <= '0;
                        // No wait for the host read [R6] [R10]
                        if (chan != 2'h0 || (seq && run)) begin
                            st <= S_CONV;
                        end else begin
                            st <= S_IDLE;
                        end
                    end
                end
                default: begin
                    st <= S_IDLE;
                end
            endcase
        end
    end

    // Holds each channel's count until the scan completes [R11]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NCH; i++) begin
                shadow[i] <= '0;
            end
        end else if (conv_end) begin
            shadow[chan] <= sens_next;
        end
    end

    // Publishes every channel at once on scan end [R4] [R11]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NCH; i++) begin
                res[i] <= '0;
            end
        end else if (scan_done) begin
            for (int i = 0; i < NCH - 1; i++) begin
                res[i] <= shadow[i];
            end
            res[NCH-1] <= sens_next;
        end
    end

    // Fresh data flag; a new scan wins over a read [R4] [R5]
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            unread <= 1'b0;
        end else if (scan_done) begin
            unread <= 1'b1;
        end else if (res_rd) begin
            unread <= 1'b0;
        end
    end

    // ==========================================================
    // Register writes
    // ==========================================================
    // Reference counts and configuration
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NCH; i++) begin
                rcount[i] <= RCNT_RST;
            end
            cfg <= CFG_RST;
        end else begin
            // Single scan mode drops run after one scan
            if (scan_done && !seq) begin
                cfg[CFG_RUN_BIT] <= 1'b0;
            end
            if (bus_i.wr) begin
                if (bus_i.addr[7:4] == OFS_RCNT[7:4]
                    && bus_i.addr[1:0] == 2'h0) begin
                    rcount[bus_i.addr[3:2]] <= bus_i.wdata[RC_W-1:0];
                end
                if (bus_i.addr == OFS_CFG) begin
                    cfg <= bus_i.wdata[2:0];
                end
            end
        end
    end

    // Sticky events; a new event wins over the clear
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat <= '0;
            mask <= MASK_RST;
        end else begin
            if (bus_i.wr && bus_i.addr == OFS_MASK) begin
                mask <= bus_i.wdata[IRQ_W-1:0];
            end
            if (bus_i.wr && bus_i.addr == OFS_STAT) begin
                stat <= (stat & ~bus_i.wdata[IRQ_W-1:0])
                      | {scan_done && unread, scan_done};
            end else begin
                stat <= stat | {scan_done && unread, scan_done};
            end
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    logic [DATA_W-1:0] next_rdata;   // Read data for next cycle
    logic [RES_W-1:0]  rsel;         // Addressed result

    // Decodes the read address; unmapped reads give zero
    always_comb begin
        rsel       = res[bus_i.addr[4:3]];
        next_rdata = '0;
        if (bus_i.addr < OFS_RCNT && bus_i.addr[1:0] == 2'h0) begin
            if (!bus_i.addr[2]) begin
                next_rdata = DATA_W'(rsel[RES_W-1:RES_SPLIT]);
            end else begin
                next_rdata = DATA_W'(rsel[RES_SPLIT-1:0]);
            end
        end else if (bus_i.addr[7:4] == OFS_RCNT[7:4]
                     && bus_i.addr[1:0] == 2'h0) begin
            next_rdata = DATA_W'(rcount[bus_i.addr[3:2]]);
        end else begin
            case (bus_i.addr)
                OFS_CFG:   next_rdata = DATA_W'(cfg);
                OFS_STAT:  next_rdata = DATA_W'(stat);
                OFS_MASK:  next_rdata = DATA_W'(mask);
                OFS_STATE: next_rdata = DATA_W'({unread, st, chan});
                default:   next_rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // All outputs are registered
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o             <= '0;
            irq_o               <= 1'b0;
            data_ready_irq_n_o  <= 1'b1;
            data_ready_irq_oe_o <= 1'b0;
            i2c_dev_addr_o      <= I2C_ADDR_LOW;
        end else begin
            rdata_o <= bus_i.rd ? next_rdata : '0;
            irq_o   <= |(stat & mask);
            // Pin low while data unread, released if disabled [R7]
            data_ready_irq_n_o  <= !(unread && !dis); // [R4] [R5]
            data_ready_irq_oe_o <= !dis; // [R7]
            // Address from the select pin [R9]
            i2c_dev_addr_o <= sel_s2 ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    one_chan_a: assert property (@(posedge sys_clk_i) // [R1]
        disable iff (!rstn_i)
        (st == S_CONV && $past(st) == S_CONV) |-> $stable(chan))
        else $error("channel changed mid conversion");

    conv_len_a: assert property (@(posedge sys_clk_i) // [R2]
        disable iff (!rstn_i)
        (st == S_CONV && ref_rise && ref_cnt == conv_len - CNT_W'(1))
        |=> (st == S_SWITCH && ref_cnt == $past(conv_len)))
        else $error("conversion length wrong");

    scan_end_a: assert property (@(posedge sys_clk_i) // [R3]
        disable iff (!rstn_i)
        scan_done |-> (chan == 2'h3 && st == S_CONV))
        else $error("scan ended before last channel");

    res_load_a: assert property (@(posedge sys_clk_i) // [R4]
        disable iff (!rstn_i)
        scan_done |=> (unread && res[0] == $past(shadow[0]))
        ##1 (!data_ready_irq_n_o || dis))
        else $error("scan end did not publish data");

    read_clr_a: assert property (@(posedge sys_clk_i) // [R5]
        disable iff (!rstn_i)
        (res_rd && !scan_done) |=> !unread ##1 data_ready_irq_n_o)
        else $error("read did not clear data ready");

    no_wait_a: assert property (@(posedge sys_clk_i) // [R6]
        disable iff (!rstn_i)
        (scan_done && seq && run) |-> ##[1:130]
        (st == S_CONV && chan == 2'h0))
        else $error("next scan did not start");

    pin_dis_a: assert property (@(posedge sys_clk_i) // [R7]
        disable iff (!rstn_i)
        $past(dis) |-> (!data_ready_irq_oe_o))
        else $error("pin driven while disabled");

    dead_time_a: assert property (@(posedge sys_clk_i) // [R8]
        disable iff (!rstn_i)
        $rose(st == S_SWITCH) |-> ##[1:249] (st != S_SWITCH))
        else $error("dead time too long");

    addr_sel_a: assert property (@(posedge sys_clk_i) // [R9]
        disable iff (!rstn_i)
        i2c_dev_addr_o == ($past(sel_s2) ? 7'h2B : 7'h2A))
        else $error("bus address mismatch");

    seq_step_a: assert property (@(posedge sys_clk_i) // [R10]
        disable iff (!rstn_i)
        (conv_end && chan != 2'h3) |=> (chan == $past(chan) + 2'h1)
        ##[1:130] (st == S_CONV))
        else $error("channel sequence broken");

    atomic_a: assert property (@(posedge sys_clk_i) // [R11]
        disable iff (!rstn_i)
        !$past(scan_done) |-> ($stable(res[0]) && $stable(res[3])))
        else $error("results changed outside scan end");

endmodule

// file: icss_link_model.sv
// Reference clock and sensor oscillators seen by the sequencer
`timescale 1ns/10ps
module icss_link_model (
    output logic       ref_clk_o,
    output logic [3:0] sensor_o
);
    // ==========================================================
    // Reference clock, a free running oscillator, 125 ns period
    // ==========================================================
    initial ref_clk_o = 1'h0;
    always #62.5 ref_clk_o = ~ref_clk_o;

    // ==========================================================
    // Sensor tanks; channel n swings with period 100*(n+1) ns
    // ==========================================================
    for (genvar g = 0; g < 4; g++) begin : g_osc
        logic osc = 1'h0; // Tank level, distinct rate per channel
        always #(50 * (g + 1)) osc = ~osc;
        assign sensor_o[g] = osc;
    end
endmodule

// file: testbench.sv
// Self-checking bench for the inductive channel scan sequencer
`timescale 1ns/10ps
module testbench;
    import icss_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    logic              sys_clk_i  = 1'h0; // 250 MHz clock
    logic              rstn_i     = 1'h0; // Reset, active low
    icss_bus_req_t     bus        = '0;   // Register request
    logic [DATA_W-1:0] rdata;             // Read data
    logic              ref_clk;           // Reference clock
    logic [NCH-1:0]    sensor;            // Sensor tanks
    logic              addr_sel   = 1'h0; // Address select pin
    logic              dr_n;              // Data ready pin level
    logic              dr_oe;             // Data ready pin enable
    logic              irq;               // Level interrupt
    logic [6:0]        dev_addr;          // Bus address
    integer            error_cnt  = 0;    // Mismatches
    integer            n_compared = 0;    // Comparisons
    integer            cyc        = 0;    // Clock count
    integer            dur [NCH];         // Measured conversion cycles

    // Clock and cycle counter
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) cyc <= cyc + 1;

    icss_link_model LINK (.ref_clk_o(ref_clk), .sensor_o(sensor));

    icss_scan_seq DUT (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata),
        .ref_clk_i(ref_clk), .sensor_i(sensor), .addr_sel_i(addr_sel),
        .data_ready_irq_n_o(dr_n), .data_ready_irq_oe_o(dr_oe),
        .irq_o(irq), .i2c_dev_addr_o(dev_addr)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Let n edges pass, then settle
    task automatic wait_cyc(input integer n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // One cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge sys_clk_i);
        bus <= '0;
    endtask

    // One cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge sys_clk_i);
        bus <= '0;
        #1;
        d = rdata;
    endtask

    // Same reference count on every channel
    task automatic set_rc(input logic [31:0] rc);
        for (int c = 0; c < NCH; c++) wr(8'(OFS_RCNT + 4 * c), rc);
    endtask

    // Follow the live state through one scan, timing each phase
    task automatic scan_poll(input bit chk, input integer rc);
        logic [31:0] s;
        logic [2:0]  st;
        logic [2:0]  pst;
        integer      ch, n, t0, nref;
        pst = 3'h1;
        ch = 0;
        n = 0;
        t0 = cyc;
        nref = rc * CONV_MUL + CONV_ADD;
        while (ch < NCH && n < 4000) begin
            rd(OFS_STATE, s);
            st = s[4:2];
            n++;
            if (st != pst) begin
                if (st == 3'h2) begin
                    check("channel", s[1:0], ch[1:0]);
                    if (ch == 3 && chk) check("early ready", dr_n, 1);
                end
                if (pst == 3'h4) check("dead time", cyc - t0 < 250, 1);
                if (pst == 3'h2) begin
                    dur[ch] = cyc - t0;
                    if (chk) check("conv len",
                        dur[ch] >= (nref - 1) * 125 / 4 - 4 &&
                        dur[ch] <= nref * 125 / 4 + 12, 1);
                    ch++;
                end
                t0 = cyc;
            end
            pst = st;
        end
        check("scan ends", n < 4000, 1);
    endtask

    // Every channel's count matches the tank rate over its own window
    task automatic chk_results();
        logic [31:0] hi, lo;
        integer      e, r;
        for (int c = 0; c < NCH; c++) begin
            rd(8'(OFS_RES + 8 * c), hi);
            rd(8'(OFS_RES + 8 * c + 4), lo);
            e = dur[c] * CLK_NS / (100 * (c + 1));
            r = {hi[11:0], lo[15:0]};
            check("result", r >= e - 3 && r <= e + 3, 1);
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Reset values, read-only and unmapped places
    task automatic t_reset();
        logic [31:0] d;
        check("pin enable", dr_oe, 1);
        check("ready pin", dr_n, 1);
        check("irq", irq, 0);
        rd(OFS_CFG, d);
        check("cfg", d, 32'h2);
        for (int c = 0; c < NCH; c++) begin
            rd(8'(OFS_RCNT + 4 * c), d);
            check("rcount", d, 32'h80);
        end
        rd(OFS_MASK, d);
        check("mask", d, 32'h0);
        rd(OFS_STAT, d);
        check("status", d, 32'h0);
        rd(OFS_STATE, d);
        check("state", d, 32'h4);
        wr(OFS_RES, 32'hFFFFFFFF);
        rd(OFS_RES, d);
        check("ro result", d, 32'h0);
        rd(8'h40, d);
        check("unmapped", d, 32'h0);
    endtask

    // Bus address follows the select pin
    task automatic t_addr();
        check("dev addr", dev_addr, 32'h2A);
        @(posedge sys_clk_i) addr_sel <= 1'h1;
        wait_cyc(6);
        check("dev addr", dev_addr, 32'h2B);
        @(posedge sys_clk_i) addr_sel <= 1'h0;
        wait_cyc(6);
        check("dev addr", dev_addr, 32'h2A);
    endtask

    // One scan, data ready held until a result is read
    task automatic t_single(input logic [31:0] rc);
        logic [31:0] d;
        set_rc(rc);
        wr(OFS_CFG, 32'h4);
        scan_poll(1, rc);
        wait_cyc(3);
        check("ready low", dr_n, 0);
        rd(OFS_STAT, d);
        check("done flag", d[0], 1);
        rd(OFS_CFG, d);
        check("run cleared", d, 32'h0);
        check("ready kept", dr_n, 0);
        chk_results();
        wait_cyc(1);
        check("ready released", dr_n, 1);
        wr(OFS_STAT, 32'h3);
    endtask

    // Sequence mode keeps converting with data unread
    task automatic t_seq();
        logic [31:0] d;
        integer      n;
        set_rc(32'h1);
        wr(OFS_CFG, 32'h6);
        scan_poll(1, 1);
        wait_cyc(3);
        check("ready low", dr_n, 0);
        n = 0;
        do begin
            rd(OFS_STATE, d);
            n++;
        end while (!(d[4:2] == 3'h2 && d[1:0] == 2'h0) && n < 100);
        check("restart", n < 100, 1);
        check("ready held", dr_n, 0);
        scan_poll(0, 1);
        rd(OFS_STAT, d);
        check("overrun", d, 32'h3);
        // Stop request lands inside the next scan, not in the dead time
        n = 0;
        do begin
            rd(OFS_STATE, d);
            n++;
        end while (d[4:2] != 3'h2 && n < 100);
        check("restart", n < 100, 1);
        wr(OFS_CFG, 32'h2);
        scan_poll(0, 1);
        wait_cyc(200);
        rd(OFS_STATE, d);
        check("stopped", d[4:2], 3'h1);
        chk_results();
    endtask

    // Sticky status, mask and level interrupt
    task automatic t_irq();
        logic [31:0] d;
        check("irq masked", irq, 0);
        wr(OFS_MASK, 32'h1);
        wait_cyc(2);
        check("irq on", irq, 1);
        wr(OFS_STAT, 32'h1);
        wait_cyc(2);
        check("irq off", irq, 0);
        rd(OFS_STAT, d);
        check("status", d, 32'h2);
        wr(OFS_MASK, 32'h3);
        wait_cyc(2);
        check("irq on", irq, 1);
        wr(OFS_STAT, 32'h2);
        wait_cyc(2);
        check("irq off", irq, 0);
        rd(OFS_STAT, d);
        check("status", d, 32'h0);
    endtask

    // Disabled pin is not driven, even across a scan end
    task automatic t_dis();
        logic [31:0] d;
        wr(OFS_CFG, 32'h5);
        wait_cyc(2);
        check("pin off", dr_oe, 0);
        scan_poll(0, 1);
        wait_cyc(3);
        check("pin off", dr_oe, 0);
        rd(OFS_STAT, d);
        check("done flag", d[0], 1);
        chk_results();
        wr(OFS_CFG, 32'h0);
        wait_cyc(2);
        check("pin on", dr_oe, 1);
    endtask

    // ==========================================================
    // Verdict, main sequence and watchdog
    // ==========================================================
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'h1;
        wait_cyc(1);
        t_reset();
        t_addr();
        t_single(32'h1);
        t_single(32'h2);
        t_seq();
        t_irq();
        t_dis();
        tally_and_finish();
    end

    // Whole run is near 80 us; a hang is cut well beyond that
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
